// File: kgcb_bank.sv
`timescale 1ns/1ps
// Operation
// - delay code n gives (n+1)*8 debounce cycles
// - rate code n gives (n+1)*4 debounce cycles
// - autorepeat only while enable bit set
// - autosleep code selects timeout, zero disables
// - rotary bit pairs ports six and seven
// - timeout irq set, cleared by flag read
// - gpio disabled: circuits off, direction writes ignored
// - disabled plus key sleep means full shutdown
// - gpio enabled keeps circuits running always
// - reset bit restores gpio registers, self clears
// - fade codes 1 to 5 ramp in sixteen steps
// - fade code sizes total time 256-4096 ms
// - direction bit per port, one is output
// - debounce cycle comes from debounce time field
module kgcb_bank #(
	parameter int P_MS_CYCLES = kgcb_pkg::MS_CYCLES
) (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rst,
	// register access from the serial slave
	input wire kgcb_pkg::kgcb_req_t i_req,
	output logic [7:0] o_rdata,
	output logic o_rhit,
	// key-scan and bus state
	input wire logic [4:0] i_debounce_code,
	input wire logic i_key_sleep,
	input wire logic i_key_held,
	input wire logic i_key_activity,
	input wire logic i_bus_timeout,
	// key section controls
	output logic o_key_repeat,
	output logic o_autosleep,
	// gpio section controls
	output logic o_rotary_input_pair,
	output logic [7:0] o_port_dir,
	output logic o_gpio_run,
	output logic o_full_shutdown,
	output logic o_gpio_soft_rst,
	output logic o_fade_active,
	output logic o_fade_step,
	output logic o_port_irq_out
);
	// the prescaler is sixteen bits wide, so larger counts cannot be served
	if (P_MS_CYCLES < 1 || P_MS_CYCLES > 65535) begin : g_bad_ms_cycles
		$error("P_MS_CYCLES out of range");
	end

	logic [7:0] autorepeat;
	logic [2:0] autosleep;
	logic [7:0] global_cfg;
	logic [7:0] direction;
	logic soft_rst;
	logic irq;
	logic [7:0] rdata;
	logic rhit;
	logic [7:0] next_autorepeat;
	logic [2:0] next_autosleep;
	logic [7:0] next_global_cfg;
	logic [7:0] next_direction;
	logic next_soft_rst;
	logic next_irq;
	logic [7:0] next_rdata;
	logic next_rhit;
	logic gpio_en;
	logic wr_reset;

	assign gpio_en = global_cfg[kgcb_pkg::GC_ENABLE_BIT];
	assign wr_reset = i_req.wr && i_req.addr == kgcb_pkg::ADDR_GLOBAL
		&& i_req.wdata[kgcb_pkg::GC_RESET_BIT];

	// register writes; reset bit is never stored, so it always reads zero
	always_comb begin
		next_autorepeat = autorepeat;
		next_autosleep = autosleep;
		next_global_cfg = global_cfg;
		next_direction = direction;
		next_soft_rst = 1'b0;
		if (wr_reset) begin
			next_global_cfg = 8'h00;
			next_direction = kgcb_pkg::RST_DIRECTION;
			next_soft_rst = 1'b1;
		end else if (i_req.wr) begin
			if (i_req.addr == kgcb_pkg::ADDR_AUTOREPEAT) begin
				next_autorepeat = i_req.wdata;
			end else if (i_req.addr == kgcb_pkg::ADDR_AUTOSLEEP) begin
				next_autosleep = i_req.wdata[2:0];
			end else if (i_req.addr == kgcb_pkg::ADDR_GLOBAL) begin
				next_global_cfg = i_req.wdata & kgcb_pkg::GC_WRITE_MASK;
			end else if (i_req.addr == kgcb_pkg::ADDR_DIRECTION && gpio_en) begin
				next_direction = i_req.wdata;
			end
		end
	end

	// read data is registered one cycle after the read strobe
	always_comb begin
		next_rdata = 8'h00;
		next_rhit = 1'b0;
		if (i_req.rd) begin
			next_rhit = 1'b1;
			if (i_req.addr == kgcb_pkg::ADDR_AUTOREPEAT) begin
				next_rdata = autorepeat;
			end else if (i_req.addr == kgcb_pkg::ADDR_AUTOSLEEP) begin
				next_rdata = {5'h00, autosleep};
			end else if (i_req.addr == kgcb_pkg::ADDR_GLOBAL) begin
				next_rdata = global_cfg;
			end else if (i_req.addr == kgcb_pkg::ADDR_DIRECTION) begin
				next_rdata = direction;
			end else begin
				next_rhit = 1'b0;
			end
		end
	end

	// timeout irq: a new timeout wins over a same-cycle flag read
	always_comb begin
		next_irq = irq;
		if (i_req.rd && i_req.addr == kgcb_pkg::ADDR_TIMEOUT_FLAG) begin
			next_irq = 1'b0;
		end
		if (i_bus_timeout && global_cfg[kgcb_pkg::GC_TMO_IRQ_BIT]) begin
			next_irq = 1'b1;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			autorepeat <= kgcb_pkg::RST_AUTOREPEAT;
			autosleep <= kgcb_pkg::RST_AUTOSLEEP;
			global_cfg <= 8'h00;
			direction <= kgcb_pkg::RST_DIRECTION;
			soft_rst <= 1'b0;
			irq <= 1'b0;
			rdata <= 8'h00;
			rhit <= 1'b0;
		end else begin
			autorepeat <= next_autorepeat;
			autosleep <= next_autosleep;
			global_cfg <= next_global_cfg;
			direction <= next_direction;
			soft_rst <= next_soft_rst;
			irq <= next_irq;
			rdata <= next_rdata;
			rhit <= next_rhit;
		end
	end

	// millisecond tick and debounce cycle tick
	logic [15:0] pre;
	logic [5:0] db_ms;
	logic ms_tick;
	logic db_tick;
	logic [15:0] next_pre;
	logic [5:0] next_db_ms;
	logic next_ms_tick;
	logic next_db_tick;
	logic [5:0] db_len;

	always_comb begin
		db_len = 6'(i_debounce_code + 6'(kgcb_pkg::DEBOUNCE_BASE_MS));
		next_pre = 16'(pre + 16'h0001);
		next_ms_tick = 1'b0;
		next_db_ms = db_ms;
		next_db_tick = 1'b0;
		if (pre >= 16'(P_MS_CYCLES - 1)) begin
			next_pre = 16'h0000;
			next_ms_tick = 1'b1;
		end
		if (ms_tick) begin
			if (6'(db_ms + 6'h01) >= db_len) begin
				next_db_ms = 6'h00;
				next_db_tick = 1'b1;
			end else begin
				next_db_ms = 6'(db_ms + 6'h01);
			end
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			pre <= 16'h0000;
			db_ms <= 6'h00;
			ms_tick <= 1'b0;
			db_tick <= 1'b0;
		end else begin
			pre <= next_pre;
			db_ms <= next_db_ms;
			ms_tick <= next_ms_tick;
			db_tick <= next_db_tick;
		end
	end

	// autosleep: idle time in ms, one pulse per idle period
	logic [13:0] idle_ms;
	logic slept;
	logic sleep_pulse;
	logic [13:0] next_idle_ms;
	logic next_slept;
	logic next_sleep_pulse;
	logic [13:0] sleep_lim;

	always_comb begin
		if (autosleep == 3'h7) begin
			sleep_lim = 14'(kgcb_pkg::SLEEP_MIN_MS);
		end else begin
			sleep_lim = 14'(kgcb_pkg::SLEEP_MAX_MS >> (autosleep - 3'h1));
		end
		next_idle_ms = idle_ms;
		next_slept = slept;
		next_sleep_pulse = 1'b0;
		if (i_key_activity || autosleep == 3'h0) begin
			next_idle_ms = 14'h0000;
			next_slept = 1'b0;
		end else if (ms_tick && !slept) begin
			if (14'(idle_ms + 14'h0001) >= sleep_lim) begin
				next_sleep_pulse = 1'b1;
				next_slept = 1'b1;
				next_idle_ms = 14'h0000;
			end else begin
				next_idle_ms = 14'(idle_ms + 14'h0001);
			end
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			idle_ms <= 14'h0000;
			slept <= 1'b0;
			sleep_pulse <= 1'b0;
		end else begin
			idle_ms <= next_idle_ms;
			slept <= next_slept;
			sleep_pulse <= next_sleep_pulse;
		end
	end

	// fade step timer; undefined codes are treated as no fading
	logic [8:0] fade_ms;
	logic fade_pulse;
	logic [8:0] next_fade_ms;
	logic next_fade_pulse;
	logic [2:0] fade_code;
	logic fade_on;
	logic [8:0] step_lim;

	assign fade_code = global_cfg[kgcb_pkg::GC_FADE_LSB +: 3];
	assign fade_on = fade_code != 3'h0 && fade_code <= 3'h5 && gpio_en;

	always_comb begin
		// step length is total time over sixteen steps
		step_lim = 9'((kgcb_pkg::FADE_BASE_MS / kgcb_pkg::FADE_STEPS)
			<< (fade_code - 3'h1));
		next_fade_ms = fade_ms;
		next_fade_pulse = 1'b0;
		if (!fade_on) begin
			next_fade_ms = 9'h000;
		end else if (ms_tick) begin
			if (9'(fade_ms + 9'h001) >= step_lim) begin
				next_fade_ms = 9'h000;
				next_fade_pulse = 1'b1;
			end else begin
				next_fade_ms = 9'(fade_ms + 9'h001);
			end
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			fade_ms <= 9'h000;
			fade_pulse <= 1'b0;
		end else begin
			fade_ms <= next_fade_ms;
			fade_pulse <= next_fade_pulse;
		end
	end

	// autorepeat engine
	kgcb_repeat u_repeat (
		.i_clock(i_clock),
		.i_rst(i_rst),
		.i_enable(autorepeat[kgcb_pkg::AR_ENABLE_BIT]),
		.i_delay_code(autorepeat[kgcb_pkg::AR_DELAY_LSB +: 4]),
		.i_rate_code(autorepeat[kgcb_pkg::AR_RATE_LSB +: 3]),
		.i_db_tick(db_tick),
		.i_key_held(i_key_held),
		.o_repeat(o_key_repeat)
	);

	// outputs
	assign o_rdata = rdata;
	assign o_rhit = rhit;
	assign o_autosleep = sleep_pulse;
	assign o_rotary_input_pair = global_cfg[kgcb_pkg::GC_ROTARY_BIT];
	assign o_port_dir = direction;
	assign o_gpio_run = gpio_en;
	assign o_full_shutdown = !gpio_en && i_key_sleep;
	assign o_gpio_soft_rst = soft_rst;
	assign o_fade_active = fade_on;
	assign o_fade_step = fade_pulse;
	assign o_port_irq_out = irq;
endmodule : kgcb_bank

// File: kgcb_bank_properties.sv
`timescale 1ns/1ps
// checks on the bank's register port and the controls derived from it
module kgcb_bank_properties #(
	parameter int P_MS_CYCLES = 50000
) (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rst,
	// register port
	input wire kgcb_pkg::kgcb_req_t i_req,
	input wire logic [7:0] o_rdata,
	input wire logic o_rhit,
	// key and bus state
	input wire logic i_key_sleep,
	input wire logic i_key_held,
	input wire logic i_bus_timeout,
	// controls
	input wire logic o_key_repeat,
	input wire logic o_rotary_input_pair,
	input wire logic [7:0] o_port_dir,
	input wire logic o_gpio_run,
	input wire logic o_full_shutdown,
	input wire logic o_gpio_soft_rst,
	input wire logic o_fade_active,
	input wire logic o_fade_step,
	input wire logic o_port_irq_out
);
	// request decode; only four addresses live in this bank
	wire logic hit_a = i_req.addr inside {8'h05, 8'h06, 8'h40, 8'h41};
	wire logic wr_dir = i_req.wr && i_req.addr == 8'h41;
	wire logic wr_glb = i_req.wr && i_req.addr == 8'h40;
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_rst);
	property p_rd_hit; i_req.rd && hit_a |=> o_rhit; endproperty
	a_rd_hit: assert property (p_rd_hit)
		else $error("mapped read gave no hit");
	property p_rd_miss; i_req.rd && !hit_a |=> !o_rhit && o_rdata == 8'h00; endproperty
	a_rd_miss: assert property (p_rd_miss)
		else $error("unmapped read answered");
	property p_dir_wr; wr_dir && o_gpio_run |=> o_port_dir == $past(i_req.wdata); endproperty
	a_dir_wr: assert property (p_dir_wr)
		else $error("direction write lost");
	property p_dir_lock; wr_dir && !o_gpio_run |=> $stable(o_port_dir); endproperty
	a_dir_lock: assert property (p_dir_lock)
		else $error("direction changed while disabled");
	property p_shut; o_full_shutdown == (!o_gpio_run && i_key_sleep); endproperty
	a_shut: assert property (p_shut)
		else $error("shutdown level wrong");
	property p_irq_clr; i_req.rd && i_req.addr == 8'h48 && !i_bus_timeout |=> !o_port_irq_out;
	endproperty
	a_irq_clr: assert property (p_irq_clr)
		else $error("irq not cleared by flag read");
	property p_soft;
		wr_glb && i_req.wdata[3] |=> o_gpio_soft_rst && o_port_dir == 8'h00 && !o_gpio_run
			##1 !o_gpio_soft_rst;
	endproperty
	a_soft: assert property (p_soft)
		else $error("soft reset wrong");
	property p_cfg;
		wr_glb && !i_req.wdata[3] |=> o_rotary_input_pair == $past(i_req.wdata[7])
			&& o_gpio_run == $past(i_req.wdata[4]);
	endproperty
	a_cfg: assert property (p_cfg)
		else $error("global bits not stored");
	property p_rep_held; o_key_repeat |-> $past(i_key_held); endproperty
	a_rep_held: assert property (p_rep_held)
		else $error("repeat without held key");
	property p_fade; o_fade_step |-> $past(o_fade_active); endproperty
	a_fade: assert property (p_fade)
		else $error("fade step while not fading");
	// main scenarios reached
	c_rep: cover property (o_key_repeat);
	c_soft: cover property (o_gpio_soft_rst);
	c_irq: cover property (o_port_irq_out ##1 !o_port_irq_out);
endmodule : kgcb_bank_properties

bind kgcb_bank kgcb_bank_properties #(.P_MS_CYCLES(P_MS_CYCLES)) u_kgcb_bank_properties (
	.i_clock, .i_rst, .i_req, .o_rdata, .o_rhit, .i_key_sleep, .i_key_held, .i_bus_timeout,
	.o_key_repeat, .o_rotary_input_pair, .o_port_dir, .o_gpio_run, .o_full_shutdown,
	.o_gpio_soft_rst, .o_fade_active, .o_fade_step, .o_port_irq_out
);

// File: kgcb_bank_tb.sv
`timescale 1ns/1ps
module kgcb_bank_tb;
	localparam int MS = 10;
	logic i_clock = 1'b0;
	logic i_rst = 1'b1;
	kgcb_pkg::kgcb_req_t i_req;
	logic [7:0] o_rdata, o_port_dir, s;
	logic [4:0] i_debounce_code = 5'h00;
	logic i_key_sleep = 1'b0, i_key_held = 1'b0, i_key_activity = 1'b0, i_bus_timeout = 1'b0;
	logic o_rhit, o_key_repeat, o_autosleep, o_rotary_input_pair, o_gpio_run;
	logic o_full_shutdown, o_gpio_soft_rst, o_fade_active, o_fade_step, o_port_irq_out;
	int err_total = 0, n_checks = 0, cyc = 0, n, t;

	kgcb_bank #(.P_MS_CYCLES(MS)) u_kgcb_bank (
		.i_clock, .i_rst, .i_req, .o_rdata, .o_rhit, .i_debounce_code, .i_key_sleep,
		.i_key_held, .i_key_activity, .i_bus_timeout, .o_key_repeat, .o_autosleep,
		.o_rotary_input_pair, .o_port_dir, .o_gpio_run, .o_full_shutdown, .o_gpio_soft_rst,
		.o_fade_active, .o_fade_step, .o_port_irq_out
	);
	kgcb_host u_kgcb_host (.i_clock, .o_req(i_req), .i_rdata(o_rdata), .i_rhit(o_rhit));

	// clock, and a ceiling about twice the expected run
	always #10 i_clock = ~i_clock;
	always @(posedge i_clock) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			err_total++;
			give_verdict();
		end
	end

	task automatic chk(input string nm, input logic [31:0] v, input logic [31:0] e);
		n_checks++;
		if (v !== e) begin
			err_total++;
			$display("[ERR] %s expected %0h seen %0h", nm, e, v);
		end
	endtask : chk
	task automatic rdc(input logic [7:0] a, input logic [7:0] e, input logic h);
		logic [7:0] d;
		logic k;
		u_kgcb_host.rd_reg(a, d, k);
		chk("rdata", 32'(d), 32'(e));
		chk("rhit", 32'(k), 32'(h));
	endtask : rdc
	// cycles until the chosen event pulse, capped at lim
	task automatic wev(input int sel, input int lim, output int m);
		m = 0;
		do begin
			@(posedge i_clock);
			#1 m++;
		end while (m < lim && (sel == 0 ? o_key_repeat : sel == 1 ? o_autosleep
			: o_fade_step) !== 1'b1);
	endtask : wev
	task automatic pulse_tmo;
		@(posedge i_clock) i_bus_timeout <= 1'b1;
		@(posedge i_clock) i_bus_timeout <= 1'b0;
		#1;
	endtask : pulse_tmo
	task automatic poke;
		@(posedge i_clock) i_key_activity <= 1'b1;
		@(posedge i_clock) i_key_activity <= 1'b0;
	endtask : poke
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : give_verdict

	// main sequence
	initial begin
		repeat (10) @(posedge i_clock);
		i_rst <= 1'b0;
		rdc(8'h05, 8'h00, 1'b1);
		rdc(8'h06, 8'h07, 1'b1);
		rdc(8'h40, 8'h00, 1'b1);
		rdc(8'h41, 8'h00, 1'b1);
		rdc(8'h07, 8'h00, 1'b0);
		i_key_sleep <= 1'b1;
		u_kgcb_host.wr_reg(8'h41, 8'hFF);
		rdc(8'h41, 8'h00, 1'b1);
		chk("shutdown", 32'(o_full_shutdown), 32'h1);
		u_kgcb_host.wr_reg(8'h40, 8'hF7);
		rdc(8'h40, 8'hB7, 1'b1);
		chk("rotary", 32'(o_rotary_input_pair), 32'h1);
		chk("run", 32'(o_gpio_run), 32'h1);
		chk("shutdown", 32'(o_full_shutdown), 32'h0);
		u_kgcb_host.wr_reg(8'h41, 8'hA5);
		rdc(8'h41, 8'hA5, 1'b1);
		chk("dir", 32'(o_port_dir), 32'hA5);
		u_kgcb_host.wr_reg(8'h06, 8'hFF);
		rdc(8'h06, 8'h07, 1'b1);
		u_kgcb_host.wr_reg(8'h40, 8'h08);
		chk("soft_rst", 32'(o_gpio_soft_rst), 32'h1);
		rdc(8'h40, 8'h00, 1'b1);
		rdc(8'h41, 8'h00, 1'b1);
		$display("test registers done");
		u_kgcb_host.wr_reg(8'h40, 8'h10);
		pulse_tmo();
		chk("irq", 32'(o_port_irq_out), 32'h0);
		u_kgcb_host.wr_reg(8'h40, 8'h30);
		pulse_tmo();
		chk("irq", 32'(o_port_irq_out), 32'h1);
		rdc(8'h48, 8'h00, 1'b0);
		chk("irq", 32'(o_port_irq_out), 32'h0);
		$display("test irq done");
		// codes 0 then 1 time the repeat; the debounce tick runs free, so its first may come early
		for (int i = 0; i < 2; i++) begin
			s = i == 0 ? 8'h80 : 8'h9F;
			t = (kgcb_pkg::DEBOUNCE_BASE_MS + i) * MS;
			u_kgcb_host.wr_reg(8'h05, s);
			@(posedge i_clock);
			i_debounce_code <= 5'(i);
			i_key_held <= 1'b1;
			wev(0, 20000, n);
			chk("first", 32'(n + t >= (s[3:0] + 1) * 8 * t && n <= (s[3:0] + 1) * 8 * t + 2),
				32'h1);
			wev(0, 20000, n);
			chk("gap", 32'(n), 32'((s[6:4] + 1) * 4 * t));
			@(posedge i_clock) i_key_held <= 1'b0;
		end
		u_kgcb_host.wr_reg(8'h05, 8'h1F);
		@(posedge i_clock) i_key_held <= 1'b1;
		wev(0, 1500, n);
		chk("no_rep", 32'(n), 32'd1500);
		$display("test autorepeat done");
		u_kgcb_host.wr_reg(8'h06, 8'h06);
		poke();
		wev(1, 3000, n);
		chk("sleep", 32'(n >= 2545 && n <= 2575), 32'h1);
		u_kgcb_host.wr_reg(8'h06, 8'h00);
		poke();
		wev(1, 3000, n);
		chk("no_sleep", 32'(n), 32'd3000);
		$display("test autosleep done");
		for (int c = 0; c < 8; c++) begin
			u_kgcb_host.wr_reg(8'h40, 8'h10 | 8'(c));
			chk("fading", 32'(o_fade_active), 32'(c inside {[1:5]}));
			if (c inside {[1:5]}) begin
				wev(2, 3000, n);
				wev(2, 3000, n);
				chk("step", 32'(n), 32'((256 << (c - 1)) / 16 * MS));
			end
		end
		$display("test fade done");
		// a reset in mid-run must bring autorepeat, autosleep and global config back to their power-up values
		@(posedge i_clock) i_rst <= 1'b1;
		repeat (2) @(posedge i_clock);
		i_rst <= 1'b0;
		rdc(8'h05, 8'h00, 1'b1);
		rdc(8'h06, 8'h07, 1'b1);
		rdc(8'h40, 8'h00, 1'b1);
		chk("run", 32'(o_gpio_run), 32'h0);
		chk("shutdown", 32'(o_full_shutdown), 32'h1);
		$display("test reset done");
		give_verdict();
	end
endmodule : kgcb_bank_tb

// File: kgcb_host.sv
`timescale 1ns/1ps
// host side of the register port: one byte per strobe, no wait states
module kgcb_host (
	// clock
	input wire logic i_clock,
	// request out, answer back
	output kgcb_pkg::kgcb_req_t o_req,
	input wire logic [7:0] i_rdata,
	input wire logic i_rhit
);
	// idle until the first call
	initial o_req = '0;
	// released lines carry the inverse so stale values cannot pass for good ones
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clock);
		o_req <= '{1'b1, 1'b0, a, d};
		@(posedge i_clock);
		o_req <= '{1'b0, 1'b0, ~a, ~d};
		#1;
	endtask : wr_reg
	// answer stands for one cycle only, taken just after the strobe edge
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d, output logic h);
		@(posedge i_clock);
		o_req <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge i_clock);
		o_req <= '{1'b0, 1'b0, ~a, 8'hFF};
		#1 d = i_rdata;
		h = i_rhit;
	endtask : rd_reg
endmodule : kgcb_host

// File: kgcb_pkg.sv
package kgcb_pkg;
	// register offsets
	localparam logic [7:0] ADDR_AUTOREPEAT = 8'h05;
	localparam logic [7:0] ADDR_AUTOSLEEP = 8'h06;
	localparam logic [7:0] ADDR_GLOBAL = 8'h40;
	localparam logic [7:0] ADDR_DIRECTION = 8'h41;
	localparam logic [7:0] ADDR_GPIO_LAST = 8'h5F;
	localparam logic [7:0] ADDR_TIMEOUT_FLAG = 8'h48;
	// reset values
	localparam logic [7:0] RST_AUTOREPEAT = 8'h00;
	localparam logic [2:0] RST_AUTOSLEEP = 3'h7;
	localparam logic [7:0] RST_DIRECTION = 8'h00;
	// autorepeat fields
	localparam int AR_ENABLE_BIT = 7;
	localparam int AR_RATE_LSB = 4;
	localparam int AR_DELAY_LSB = 0;
	localparam int AR_DELAY_UNIT = 8;
	localparam int AR_RATE_UNIT = 4;
	// global configuration fields
	localparam int GC_ROTARY_BIT = 7;
	localparam int GC_TMO_IRQ_BIT = 5;
	localparam int GC_ENABLE_BIT = 4;
	localparam int GC_RESET_BIT = 3;
	localparam int GC_FADE_LSB = 0;
	localparam logic [7:0] GC_WRITE_MASK = 8'hB7;
	localparam logic [7:0] AS_WRITE_MASK = 8'h07;
	// timing
	localparam int CLOCK_HZ = 50_000_000;
	localparam int MS_PER_S = 1000;
	localparam int MS_CYCLES = CLOCK_HZ / MS_PER_S;
	localparam int DEBOUNCE_BASE_MS = 9;
	localparam int FADE_STEPS = 16;
	localparam int FADE_BASE_MS = 256;
	localparam int SLEEP_MAX_MS = 8192;
	localparam int SLEEP_MIN_MS = 256;

	// byte-wide register request from the serial slave engine
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} kgcb_req_t;
endpackage : kgcb_pkg

// File: kgcb_repeat.sv
`timescale 1ns/1ps
// autorepeat timing, counted in debounce cycles
module kgcb_repeat (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rst,
	// settings
	input wire logic i_enable,
	input wire logic [3:0] i_delay_code,
	input wire logic [2:0] i_rate_code,
	// timing and key state
	input wire logic i_db_tick,
	input wire logic i_key_held,
	// repeat event
	output logic o_repeat
);
	logic [7:0] count;
	logic first;
	logic fire;
	logic [7:0] next_count;
	logic next_first;
	logic next_fire;
	logic [7:0] target;

	// first repeat waits the delay, later ones the rate
	always_comb begin
		target = first ? 8'((i_delay_code + 5'h01) * kgcb_pkg::AR_DELAY_UNIT)
			: 8'((i_rate_code + 4'h1) * kgcb_pkg::AR_RATE_UNIT);
		next_count = count;
		next_first = first;
		next_fire = 1'b0;
		if (!i_enable || !i_key_held) begin
			next_count = 8'h00;
			next_first = 1'b1;
		end else if (i_db_tick) begin
			if (8'(count + 8'h01) == target) begin
				next_fire = 1'b1;
				next_count = 8'h00;
				next_first = 1'b0;
			end else begin
				next_count = 8'(count + 8'h01);
			end
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			count <= 8'h00;
			first <= 1'b1;
			fire <= 1'b0;
		end else begin
			count <= next_count;
			first <= next_first;
			fire <= next_fire;
		end
	end

	assign o_repeat = fire;
endmodule : kgcb_repeat
